// *** dv/tb_top.sv ***
// tb_top: host end and watchdog end joined by the link, driven over AHB-Lite.
// assumes a shortened second of TICK cycles.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import wdt_pkg::*;
;
  localparam int TICK = 20;
  logic mclk, rst, mode, hsel, hwrite, hready, hresp, irq, active;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] secs;
  logic [15:0] la;
  logic [7:0] lw;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int wr_cyc = 0;
  wdt_if link();
  wdt_dev #(.TICK_CYCLES(TICK)) u_wdt_dev (.MCLK(mclk), .RST(rst), .EXPIRE_IRQ_MODE(mode), .ACTIVE(active),
    .SECONDS_LEFT(secs), .link(link.dev));
  wdt_host u_wdt_host (.MCLK(mclk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .IRQ(irq), .link(link.host));
  wdt_monitor u_wdt_monitor (.MCLK(mclk), .RST(rst), .io_addr(link.io_addr), .io_wr(link.io_wr),
    .io_rd(link.io_rd), .host_oe(link.host_oe), .dev_d(link.dev_d), .dev_oe(link.dev_oe),
    .cpu_reset(link.cpu_reset), .cpu_irq(link.cpu_irq));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // only valid codes restart the count, so only they stamp the time
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (link.io_wr && link.bus_d != 8'h00 && link.bus_d <= 8'h3F)
      wr_cyc <= cyc;
    if (link.io_wr)
    begin
      la <= link.io_addr;
      lw <= link.bus_d;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  // entered just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= WDT_HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    d = hrdata;
    chk(hresp, 1'b0, "okay response");
  endtask

  task automatic link_op(input logic [1:0] op);
    ahb(1'b1, WDT_REG_CTRL, {30'h0, op});
    repeat (3) @(posedge mclk);
    ahb(1'b0, WDT_REG_RDATA, 32'h0);
  endtask

  task automatic load(input logic [7:0] code);
    ahb(1'b1, WDT_REG_INTERVAL, {24'h0, code});
    link_op(2'h1);
  endtask

  task automatic wait_exp(input int code, input logic sel);
    int n;
    n = 0;
    while ((sel ? link.cpu_irq : link.cpu_reset) !== 1'b1 && n < 1400)
    begin
      @(posedge mclk);
      n++;
    end
    chk(cyc - wr_cyc >= code * TICK && cyc - wr_cyc <= code * TICK + 4, 1'b1, "expiry time");
  endtask

  task automatic do_reset(input logic m);
    mode <= m;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic t_reset;
    do_reset(1'b0);
    ahb(1'b0, WDT_REG_INTERVAL, 32'h0);
    chk(d, 32'h1, "interval reset value");
    ahb(1'b0, WDT_REG_INT_EN, 32'h0);
    chk(d, 32'h0, "enable reset value");
    ahb(1'b0, 8'h1C, 32'h0);
    chk(d, 32'h0, "unmapped read");
    chk(active, 1'b0, "off after reset");
    $display("t_reset done");
  endtask

  task automatic t_write;
    load(8'h00);
    chk(active, 1'b0, "zero code ignored");
    load(8'h40);
    chk(active, 1'b0, "large code ignored");
    load(8'h05);
    chk(la, WDT_PORT_ADDR, "port address");
    chk(lw, 8'h05, "port data");
    chk(active, 1'b1, "write enables");
    chk(secs, 6'h05, "seconds loaded");
    ahb(1'b0, WDT_REG_INT_STATUS, 32'h0);
    chk(d[0], 1'b1, "done flag");
    link_op(2'h2);
    chk(d[7], 1'b1, "was running");
    chk(d[5:0] != 6'h00 && d[5:0] <= 6'h05, 1'b1, "seconds left");
    chk(active, 1'b0, "read disables");
    $display("t_write done");
  endtask

  task automatic t_expire;
    load(8'h01);
    wait_exp(1, 1'b0);
    // a write inside the reset pulse must be ignored, so the device stays off
    load(8'h03);
    repeat (14) @(posedge mclk);
    chk(active, 1'b0, "off after pulse");
    load(8'h3F);
    wait_exp(63, 1'b0);
    repeat (14) @(posedge mclk);
    $display("t_expire done");
  endtask

  task automatic t_refresh;
    load(8'h03);
    repeat (30) @(posedge mclk);
    load(8'h40);
    wait_exp(3, 1'b0);
    repeat (14) @(posedge mclk);
    load(8'h02);
    repeat (25) @(posedge mclk);
    load(8'h02);
    chk(secs, 6'h02, "refresh reloads");
    wait_exp(2, 1'b0);
    repeat (14) @(posedge mclk);
    $display("t_refresh done");
  endtask

  task automatic t_disable;
    ahb(1'b1, WDT_REG_INT_CLEAR, 32'h7);
    load(8'h02);
    link_op(2'h2);
    repeat (60) @(posedge mclk);
    chk(link.cpu_reset, 1'b0, "no expiry when off");
    // the sticky flag catches a pulse that came and went during the wait
    ahb(1'b0, WDT_REG_INT_STATUS, 32'h0);
    chk(d[2], 1'b0, "no reset event when off");
    link_op(2'h2);
    chk(d[7], 1'b0, "reads as stopped");
    $display("t_disable done");
  endtask

  task automatic t_irq;
    do_reset(1'b1);
    ahb(1'b1, WDT_REG_INT_EN, 32'h2);
    load(8'h01);
    wait_exp(1, 1'b1);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b1, "irq raised");
    chk(link.cpu_reset, 1'b0, "no reset in irq mode");
    ahb(1'b1, WDT_REG_INT_EN, 32'h0);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0, "irq masked");
    ahb(1'b1, WDT_REG_INT_CLEAR, 32'h7);
    ahb(1'b0, WDT_REG_INT_STATUS, 32'h0);
    chk(d[1], 1'b0, "status cleared");
    link_op(2'h2);
    chk(link.cpu_irq, 1'b0, "read drops irq");
    $display("t_irq done");
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    {mode, hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
    rst = 1'b1;
    t_reset();
    t_write();
    t_expire();
    t_refresh();
    t_disable();
    t_irq();
    results();
  end

  // the whole run needs well under 6000 cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    results();
  end
endmodule
`default_nettype wire

// *** dv/wdt_monitor.sv ***
// wdt_monitor: concurrent checks on the i/o port link between both ends.
// assumes both ends on MCLK with a synchronous active-high RST.
`timescale 1ns/1ns
`default_nettype none
module wdt_monitor
  import wdt_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic host_oe,
  input wire logic [7:0] dev_d,
  input wire logic dev_oe,
  input wire logic cpu_reset,
  input wire logic cpu_irq
);
  // pulse width is counted, too long for a repetition
  logic [4:0] rst_len;
  always_ff @(posedge MCLK)
  begin
    if (RST || !cpu_reset)
      rst_len <= 5'h00;
    else
      rst_len <= rst_len + 5'h01;
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);

  a_wr_pulse: assert property (io_wr |=> !io_wr) else $error("write strobe too long");
  a_wr_port: assert property (io_wr |-> io_addr == WDT_PORT_ADDR && host_oe) else $error("bad write cycle");
  a_rd_answer: assert property (io_rd |=> dev_oe && !cpu_irq && dev_d[6] == 1'b0)
    else $error("read not answered");
  a_oe_cause: assert property (dev_oe |-> $past(io_rd) && !host_oe) else $error("device drove unasked");
  a_rst_width: assert property ($fell(cpu_reset) |-> rst_len == 5'(WDT_RST_PULSE_CYCLES))
    else $error("reset pulse width");
  a_mode_excl: assert property (!(cpu_reset && cpu_irq)) else $error("both expiry outputs");
  a_irq_level: assert property (cpu_irq && !io_wr && !io_rd |=> cpu_irq) else $error("irq dropped");
  a_rd_quiet: assert property (dev_oe && !cpu_reset |=> (!cpu_reset && !cpu_irq)[*8])
    else $error("expiry after disable");

  c_write: cover property (io_wr);
  c_read: cover property (dev_oe);
  c_reset: cover property ($rose(cpu_reset));
  c_irq: cover property ($rose(cpu_irq));
endmodule
`default_nettype wire

// *** include/wdt_if.sv ***
// wdt_if: i/o port link between the host cpu end and the watchdog end.
// assumes both ends run on the same clock; the data bus is resolved here.
`timescale 1ns/1ns
`default_nettype none
interface wdt_if;
  logic [15:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] host_d;
  logic host_oe;
  logic [7:0] dev_d;
  logic dev_oe;
  logic [7:0] bus_d;
  logic cpu_reset;
  logic cpu_irq;

  // an undriven bus floats high
  assign bus_d = dev_oe ? dev_d : (host_oe ? host_d : wdt_pkg::WDT_IDLE_BUS);

  modport dev (
    input io_addr,
    input io_wr,
    input io_rd,
    input bus_d,
    output dev_d,
    output dev_oe,
    output cpu_reset,
    output cpu_irq
  );

  modport host (
    output io_addr,
    output io_wr,
    output io_rd,
    output host_d,
    output host_oe,
    input bus_d,
    input cpu_reset,
    input cpu_irq
  );
endinterface
`default_nettype wire

// *** include/wdt_pkg.sv ***
// wdt_pkg: constants, register map and state types shared by both ends of the
// i/o port watchdog link and its host-side controller.
// assumes one system clock MCLK at 10 MHz for both ends.
package wdt_pkg;

  // i/o port of the watchdog interval register
  localparam logic [15:0] WDT_PORT_ADDR = 16'h0443;

  // valid interval codes, in whole seconds
  localparam logic [5:0] WDT_CODE_MIN = 6'h01;
  localparam logic [5:0] WDT_CODE_MAX = 6'h3F;

  // read-back byte of the interval port
  localparam int WDT_RD_ACTIVE_BIT = 7;
  localparam logic [7:0] WDT_IDLE_BUS = 8'hFF;

  // timing
  localparam int WDT_CLK_PERIOD_NS = 100;
  localparam int WDT_SECOND_NS = 1000000000;
  localparam int WDT_TICK_CYCLES = WDT_SECOND_NS / WDT_CLK_PERIOD_NS;
  localparam int WDT_RST_PULSE_NS = 1000;
  localparam int WDT_RST_PULSE_CYCLES = (WDT_RST_PULSE_NS + WDT_CLK_PERIOD_NS - 1) / WDT_CLK_PERIOD_NS;

  // controller registers, byte offsets on AHB-Lite
  localparam logic [7:0] WDT_REG_CTRL = 8'h00;
  localparam logic [7:0] WDT_REG_INTERVAL = 8'h04;
  localparam logic [7:0] WDT_REG_STATUS = 8'h08;
  localparam logic [7:0] WDT_REG_RDATA = 8'h0C;
  localparam logic [7:0] WDT_REG_INT_STATUS = 8'h10;
  localparam logic [7:0] WDT_REG_INT_CLEAR = 8'h14;
  localparam logic [7:0] WDT_REG_INT_EN = 8'h18;

  // field positions
  localparam int WDT_CTRL_WRITE_BIT = 0;
  localparam int WDT_CTRL_READ_BIT = 1;
  localparam int WDT_STAT_BUSY_BIT = 0;
  localparam int WDT_STAT_IRQ_BIT = 1;
  localparam int WDT_STAT_RESET_BIT = 2;
  localparam int WDT_EV_DONE_BIT = 0;
  localparam int WDT_EV_IRQ_BIT = 1;
  localparam int WDT_EV_RESET_BIT = 2;
  localparam int WDT_EV_COUNT = 3;

  // reset values
  localparam logic [7:0] WDT_INTERVAL_RESET = 8'h01;
  localparam logic [2:0] WDT_INT_EN_RESET = 3'h0;

  localparam logic [1:0] WDT_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {WDT_OFF, WDT_RUN, WDT_RESETTING, WDT_IRQ_HELD} wdt_dev_state_t;
  typedef enum logic [1:0] {WDT_H_IDLE, WDT_H_WRITE, WDT_H_READ, WDT_H_CAPTURE} wdt_host_state_t;

endpackage

// *** rtl/wdt_dev.sv ***
// wdt_dev: the watchdog end, an interval port on the i/o bus with a
// one-second prescaler, a seconds counter and the expiry outputs.
// assumes i/o strobes from the host are one cycle long and on MCLK.
//
// Contract
// - expiry resets cpu or raises interrupt
// - written byte at port 443h is interval
// - codes 01h..3Fh mean 1..63 seconds
// - a port write reloads the countdown only with codes 01h..3Fh written outside a reset pulse; other writes are ignored
// - port read disables watchdog, no expiry; a read in the expiry cycle still pulses cpu_reset for one cycle in reset mode
// - write enables when off, restarts when running
`timescale 1ns/1ns
`default_nettype none
module wdt_dev
  import wdt_pkg::*;
#(
  parameter int TICK_CYCLES = WDT_TICK_CYCLES
)
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic EXPIRE_IRQ_MODE,
  output logic ACTIVE,
  output logic [5:0] SECONDS_LEFT,
  wdt_if.dev link
);

  typedef struct packed {
    wdt_dev_state_t st;
    logic [23:0] pre;
    logic [5:0] secs;
    logic [7:0] pulse;
    logic cpu_reset;
    logic cpu_irq;
    logic dev_oe;
    logic [7:0] dev_d;
    logic mode_sync;
    logic mode_irq;
  } wdt_dev_st_t;

  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
  localparam logic [7:0] PULSE_LAST = 8'(WDT_RST_PULSE_CYCLES - 1);

  wdt_dev_st_t s;
  wdt_dev_st_t next_s;

  logic hit;
  logic code_ok;
  logic wr_hit;
  logic rd_hit;
  logic tick;
  logic busy_reset;

  always_comb
  begin
    hit = (link.io_addr == WDT_PORT_ADDR);
    // codes outside 01h..3Fh are dropped so a stray byte cannot arm a zero timeout
    code_ok = (link.bus_d[7:6] == 2'h0) && (link.bus_d[5:0] >= WDT_CODE_MIN)
      && (link.bus_d[5:0] <= WDT_CODE_MAX);
    wr_hit = link.io_wr && hit && code_ok;
    rd_hit = link.io_rd && hit;
    tick = (s.pre == TICK_LAST);
    busy_reset = (s.st == WDT_RESETTING);

    next_s = s;
    next_s.dev_oe = 1'b0;

    // the mode pin is asynchronous to MCLK; two flops before expiry logic reads it
    next_s.mode_sync = EXPIRE_IRQ_MODE;
    next_s.mode_irq = s.mode_sync;

    // prescaler only runs while counting, so each load starts a full second
    if (s.st == WDT_RUN)
    begin
      next_s.pre = tick ? 24'h000000 : s.pre + 24'h000001;
    end
    else
    begin
      next_s.pre = 24'h000000;
    end

    case (s.st)
      WDT_OFF:
      begin
        next_s.cpu_irq = 1'b0;
        next_s.cpu_reset = 1'b0;
      end
      WDT_RUN:
      begin
        if (tick)
        begin
          if (s.secs == 6'h01)
          begin
            next_s.secs = 6'h00;
            if (s.mode_irq)
            begin
              next_s.st = WDT_IRQ_HELD;
              next_s.cpu_irq = 1'b1;
            end
            else
            begin
              next_s.st = WDT_RESETTING;
              next_s.cpu_reset = 1'b1;
              next_s.pulse = PULSE_LAST;
            end
          end
          else
          begin
            next_s.secs = s.secs - 6'h01;
          end
        end
      end
      WDT_RESETTING:
      begin
        // fixed-width reset pulse, then stay off until software arms again
        if (s.pulse == 8'h00)
        begin
          next_s.st = WDT_OFF;
          next_s.cpu_reset = 1'b0;
        end
        else
        begin
          next_s.pulse = s.pulse - 8'h01;
        end
      end
      WDT_IRQ_HELD:
      begin
        // interrupt is a level held until software writes a code 01h..3Fh to or reads the port
        next_s.cpu_irq = 1'b1;
      end
      default:
      begin
        next_s.st = WDT_OFF;
        next_s.cpu_irq = 1'b0;
        next_s.cpu_reset = 1'b0;
      end
    endcase

    // port read: return state, then disable; the cpu is held during a reset pulse,
    // so writes in that window are ignored and reads return state without disabling
    if (rd_hit)
    begin
      next_s.dev_oe = 1'b1;
      next_s.dev_d = {(s.st == WDT_RUN), 1'b0, s.secs};
      if (!busy_reset)
      begin
        next_s.st = WDT_OFF;
        next_s.secs = 6'h00;
        next_s.pre = 24'h000000;
        next_s.cpu_irq = 1'b0;
      end
    end

    // port write: load and start, or reload while running
    if (wr_hit && !busy_reset)
    begin
      next_s.st = WDT_RUN;
      next_s.secs = link.bus_d[5:0];
      next_s.pre = 24'h000000;
      next_s.cpu_irq = 1'b0;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      s.st <= WDT_OFF;
      s.pre <= 24'h000000;
      s.secs <= 6'h00;
      s.pulse <= 8'h00;
      s.cpu_reset <= 1'b0;
      s.cpu_irq <= 1'b0;
      s.dev_oe <= 1'b0;
      s.dev_d <= 8'h00;
      s.mode_sync <= 1'b0;
      s.mode_irq <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign link.cpu_reset = s.cpu_reset;
  assign link.cpu_irq = s.cpu_irq;
  assign link.dev_oe = s.dev_oe;
  assign link.dev_d = s.dev_d;

  // user-side view, one flop per output
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      ACTIVE <= 1'b0;
      SECONDS_LEFT <= 6'h00;
    end
    else
    begin
      ACTIVE <= (next_s.st == WDT_RUN);
      SECONDS_LEFT <= next_s.secs;
    end
  end

endmodule
`default_nettype wire

// *** rtl/wdt_host.sv ***
// wdt_host: host end; takes orders over AHB-Lite and runs i/o cycles on the
// watchdog port, with sticky event flags and one interrupt line.
// assumes a single AHB-Lite master, word accesses, same clock as the link.
`timescale 1ns/1ns
`default_nettype none
module wdt_host
  import wdt_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic IRQ,
  wdt_if.host link
);

  typedef struct packed {
    wdt_host_state_t st;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic [7:0] interval;
    logic [7:0] rdata;
    logic [2:0] ists;
    logic [2:0] ien;
    logic irq;
    logic [15:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [7:0] host_d;
    logic host_oe;
    logic prev_irq;
    logic prev_rst;
  } wdt_host_st_t;

  wdt_host_st_t s;
  wdt_host_st_t next_s;

  logic take;
  logic go_wr;
  logic go_rd;
  logic [2:0] ev;
  logic [2:0] clr;
  logic [31:0] rd_mux;

  always_comb
  begin
    take = HSEL && (HTRANS == WDT_HTRANS_NONSEQ) && HREADY;
    case (HADDR[7:0])
      WDT_REG_INTERVAL: rd_mux = {24'h000000, s.interval};
      WDT_REG_STATUS: rd_mux = {29'h00000000, link.cpu_reset, link.cpu_irq, (s.st != WDT_H_IDLE)};
      WDT_REG_RDATA: rd_mux = {24'h000000, s.rdata};
      WDT_REG_INT_STATUS: rd_mux = {29'h00000000, s.ists};
      WDT_REG_INT_EN: rd_mux = {29'h00000000, s.ien};
      default: rd_mux = 32'h00000000;
    endcase

    next_s = s;
    next_s.ap_valid = take;
    next_s.ap_write = HWRITE;
    next_s.ap_addr = HADDR[7:0];
    next_s.hrdata = (take && !HWRITE) ? rd_mux : 32'h00000000;

    go_wr = 1'b0;
    go_rd = 1'b0;
    clr = 3'h0;
    if (s.ap_valid && s.ap_write)
    begin
      case (s.ap_addr)
        WDT_REG_CTRL:
        begin
          go_wr = HWDATA[WDT_CTRL_WRITE_BIT];
          go_rd = HWDATA[WDT_CTRL_READ_BIT];
        end
        WDT_REG_INTERVAL: next_s.interval = HWDATA[7:0];
        WDT_REG_INT_CLEAR: clr = HWDATA[2:0];
        WDT_REG_INT_EN: next_s.ien = HWDATA[2:0];
        default: ;
      endcase
    end

    ev = 3'h0;
    case (s.st)
      WDT_H_IDLE:
      begin
        // write wins when both orders arrive together; orders while busy are dropped
        if (go_wr)
        begin
          next_s.st = WDT_H_WRITE;
          next_s.io_addr = WDT_PORT_ADDR;
          next_s.host_d = next_s.interval;
          next_s.host_oe = 1'b1;
          next_s.io_wr = 1'b1;
        end
        else if (go_rd)
        begin
          next_s.st = WDT_H_READ;
          next_s.io_addr = WDT_PORT_ADDR;
          next_s.io_rd = 1'b1;
        end
      end
      WDT_H_WRITE:
      begin
        next_s.io_wr = 1'b0;
        next_s.host_oe = 1'b0;
        next_s.st = WDT_H_IDLE;
        ev[WDT_EV_DONE_BIT] = 1'b1;
      end
      WDT_H_READ:
      begin
        next_s.io_rd = 1'b0;
        next_s.st = WDT_H_CAPTURE;
      end
      WDT_H_CAPTURE:
      begin
        next_s.rdata = link.bus_d;
        next_s.st = WDT_H_IDLE;
        ev[WDT_EV_DONE_BIT] = 1'b1;
      end
      default:
      begin
        next_s.st = WDT_H_IDLE;
        next_s.io_wr = 1'b0;
        next_s.io_rd = 1'b0;
        next_s.host_oe = 1'b0;
      end
    endcase

    next_s.prev_irq = link.cpu_irq;
    next_s.prev_rst = link.cpu_reset;
    ev[WDT_EV_IRQ_BIT] = link.cpu_irq && !s.prev_irq;
    ev[WDT_EV_RESET_BIT] = link.cpu_reset && !s.prev_rst;
    // a new event beats a clear in the same cycle
    next_s.ists = (s.ists & ~clr) | ev;
    next_s.irq = |(next_s.ists & next_s.ien);
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      s.st <= WDT_H_IDLE;
      s.ap_valid <= 1'b0;
      s.ap_write <= 1'b0;
      s.ap_addr <= 8'h00;
      s.hrdata <= 32'h00000000;
      s.interval <= WDT_INTERVAL_RESET;
      s.rdata <= 8'h00;
      s.ists <= 3'h0;
      s.ien <= WDT_INT_EN_RESET;
      s.irq <= 1'b0;
      s.io_addr <= 16'h0000;
      s.io_wr <= 1'b0;
      s.io_rd <= 1'b0;
      s.host_d <= 8'h00;
      s.host_oe <= 1'b0;
      s.prev_irq <= 1'b0;
      s.prev_rst <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign HRDATA = s.hrdata;
  // zero-wait slave; hreadyout and hresp are constants
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign IRQ = s.irq;
  assign link.io_addr = s.io_addr;
  assign link.io_wr = s.io_wr;
  assign link.io_rd = s.io_rd;
  assign link.host_d = s.host_d;
  assign link.host_oe = s.host_oe;

endmodule
`default_nettype wire
